// [hw/spc_pkg.sv]
// shared constants and carrier types for the speculation control block
`default_nettype none
package spc_pkg;
  localparam int VA_W = 64;
  localparam int PA_W = 40;
  localparam int ID_W = 2;
  localparam int NMISS = 1 << ID_W;

  // register map, byte addresses on the plain register port
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_MISS   = 8'h08;
  localparam logic [7:0] REG_NACKS  = 8'h0c;

  localparam int ST_KX_BIT  = 0;
  localparam int ST_SX_BIT  = 1;
  localparam int ST_UX_BIT  = 2;
  localparam int CFG_CCA_LSB = 0;
  localparam int CFG_CCA_W   = 3;
  localparam int MISS_NACK_LSB = 8;
  localparam int NACKS_W = 16;

  localparam logic [2:0]  ST_RST  = 3'h0;
  localparam logic [2:0]  CFG_RST = 3'h3;
  localparam logic [2:0]  CCA_UNCACHED = 3'h2;

  // address regions
  localparam logic [1:0]      XKPHYS_TAG = 2'h2;
  localparam int              XK_TAG_LSB = 62;
  localparam int              XK_CCA_LSB = 59;
  localparam logic [VA_W-1:0] UNMAPPED_KERNEL_CACHED_SEGMENT_LO = 64'hffffffff80000000;
  localparam logic [VA_W-1:0] UNMAPPED_KERNEL_CACHED_SEGMENT_HI = 64'hffffffff9fffffff;

  typedef enum logic [2:0] {
    OP_OTHER, OP_BRL, OP_SER, OP_CMOV, OP_LOAD, OP_STORE, OP_PREF
  } spc_op_t;

  typedef struct packed {
    logic            valid;  // instruction offered for initiation
    spc_op_t         op;
    logic            spec;   // on an unresolved speculative path
    logic            ft;     // lies in the fall-through block of a branch-likely
    logic            miss;   // memory op missed in the data cache
    logic            tlb_uc; // mapped attribute says uncached
    logic            dep_v;  // consumes data of a pending miss
    logic [ID_W-1:0] dep_id;
    logic [VA_W-1:0] addr;
  } spc_issue_t;

  typedef struct packed {
    logic            grant;    // initiated (prefetch may be dropped)
    logic            defer;    // retry later, dependency or no free miss slot
    logic            block;    // not initiated speculatively
    logic            addr_err; // address error exception
    logic            taken;    // branch predicted taken
    logic            uncached;
    logic            alloc;    // a miss slot was opened
    logic [ID_W-1:0] id;
  } spc_dec_t;

  typedef struct packed {
    logic            valid;
    logic [ID_W-1:0] id;
    logic [PA_W-1:0] addr;
  } spc_breq_t;

  typedef struct packed {
    logic            valid;
    logic            nack;
    logic [ID_W-1:0] id;
  } spc_bresp_t;
endpackage
`default_nettype wire

// [hw/spc_miss_tbl.sv]
// table of outstanding block read misses
`default_nettype none
module spc_miss_tbl import spc_pkg::*; #(
  parameter int N = NMISS
) (
  input  wire logic            clk_sys,  // core clock
  input  wire logic            rst,      // sync reset
  input  wire logic            ce,       // clock enable
  input  wire logic            alloc,    // open the free slot
  input  wire logic            rel,      // close a slot
  input  wire logic            rel_nack, // closing answer was a refusal
  input  wire logic [ID_W-1:0] rel_id,   // slot being closed
  input  wire logic            clr,      // drop refusal mark
  input  wire logic [ID_W-1:0] clr_id,   // slot whose mark drops
  output logic                 free_v,   // a slot is free
  output logic      [ID_W-1:0] free_id,  // lowest free slot
  output logic         [N-1:0] pend,     // outstanding slots
  output logic         [N-1:0] nacked    // slots refused, not yet graduated
);
  function automatic logic [ID_W-1:0] first_free(input logic [N-1:0] busy);
    logic [ID_W-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!busy[i]) r = ID_W'(i);
    end
    return r;
  endfunction

  assign free_v  = ~&pend;
  assign free_id = first_free(pend);

  for (genvar g = 0; g < N; g++) begin : g_slot
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pend[g]   <= 1'b0;
        nacked[g] <= 1'b0;
      end else if (ce) begin
        if (alloc && free_id == ID_W'(g)) begin
          pend[g]   <= 1'b1;
          nacked[g] <= 1'b0;
        end else begin
          if (rel && rel_id == ID_W'(g)) pend[g] <= 1'b0;
          // a refusal in the same cycle as a graduate clear wins
          if (rel && rel_nack && rel_id == ID_W'(g)) nacked[g] <= 1'b1;
          else if (clr && clr_id == ID_W'(g)) nacked[g] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hw/spc_ctrl.sv]
// speculation and non-blocking miss control
`default_nettype none
//
// Function
// - A branch-likely is always predicted taken.
// - Nothing in the fall-through block of a pending branch-likely is initiated.
// - After a serializing instruction only speculative memory operations are held back.
// - A conditional move never restricts speculation and is initiated like any other instruction.
// - A data miss never stalls; only instructions that use the missing data, and misses that find every miss slot busy, wait.
// - Several misses may be outstanding, and new misses open while older ones pend.
// - A prefetch is only a hint and never raises an address error or waits on a dependency.
// - The physical window splits cached and uncached by hardware; the kernel segment uses the config field.
// - With kernel wide addressing off and supervisor and user on, the physical window is denied.
// - Uncached reads and writes never go out speculatively; only cached block reads do.
module spc_ctrl import spc_pkg::*; (
  input  wire logic       clk_sys,  // 40 MHz core clock
  input  wire logic       rst,      // sync reset, active high
  input  wire logic       ce,       // clock enable, freezes all state
  input  wire spc_issue_t iss,      // instruction offered for initiation
  input  wire logic       brl_res,  // pending branch-likely resolved
  input  wire logic       ser_done, // serializing instruction completed
  input  wire logic       grad_v,   // instruction with a miss slot graduates
  input  wire logic [ID_W-1:0] grad_id, // its miss slot
  input  wire spc_bresp_t bresp,    // completion from the external agent
  input  wire logic [7:0] reg_addr, // register address
  input  wire logic [31:0] reg_wdata, // register write data
  input  wire logic       reg_wr,   // register write strobe
  input  wire logic       reg_rd,   // register read strobe
  output spc_dec_t        dec_r,    // initiation decision, one cycle after iss
  output spc_breq_t       breq_r,   // block read request
  output logic            fill_r,   // refill slot fill_id_r
  output logic [ID_W-1:0] fill_id_r, // slot being refilled
  output logic            fault_r,  // bus error at graduation
  output logic [ID_W-1:0] fault_id_r, // slot of the faulting read
  output logic [31:0]     reg_rdata_r // read data, cycle after reg_rd
);
  logic [2:0]         stat_r;   // wide addressing enables
  logic [2:0]         cca_r;    // kernel segment cache attribute
  logic [NACKS_W-1:0] nacks_r;
  logic               brl_pend_r;
  logic               ser_pend_r;
  logic               free_v;
  logic [ID_W-1:0]    free_id;
  logic [NMISS-1:0]   pend;
  logic [NMISS-1:0]   nacked;
  logic               is_mem, is_xk, is_k0, deny, unc, dep_hit;
  spc_dec_t           dec_nxt;
  logic               is_mem_q;   // checker history only
  logic               iss_pref_q; // checker history only

  spc_miss_tbl #(.N(NMISS)) u_tbl (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .alloc    (dec_nxt.alloc),
    .rel      (bresp.valid),
    .rel_nack (bresp.nack),
    .rel_id   (bresp.id),
    .clr      (grad_v),
    .clr_id   (grad_id),
    .free_v   (free_v),
    .free_id  (free_id),
    .pend     (pend),
    .nacked   (nacked)
  );

  // address classification
  always_comb begin
    is_mem = iss.op inside {OP_LOAD, OP_STORE, OP_PREF};
    is_xk  = iss.addr[XK_TAG_LSB +: 2] == XKPHYS_TAG;
    is_k0  = iss.addr >= UNMAPPED_KERNEL_CACHED_SEGMENT_LO && iss.addr <= UNMAPPED_KERNEL_CACHED_SEGMENT_HI;
    deny   = is_xk && !stat_r[ST_KX_BIT] && stat_r[ST_SX_BIT] && stat_r[ST_UX_BIT];
    if (is_xk) unc = iss.addr[XK_CCA_LSB +: 3] == CCA_UNCACHED;
    else if (is_k0) unc = cca_r == CCA_UNCACHED;
    else unc = iss.tlb_uc;
    dep_hit = iss.dep_v && pend[iss.dep_id];
  end

  // initiation decision, first match wins
  always_comb begin
    dec_nxt = '0;
    dec_nxt.uncached = iss.valid && is_mem && unc;
    dec_nxt.id = free_id;
    if (iss.valid) begin
      if (iss.ft && brl_pend_r) begin
        dec_nxt.block = 1'b1;
      end else if (is_mem && iss.spec && ser_pend_r) begin
        dec_nxt.block = 1'b1;
      end else if (iss.op == OP_PREF) begin
        // hints that cannot proceed are dropped, never faulted or held
        dec_nxt.grant = 1'b1;
        dec_nxt.alloc = iss.miss && !unc && !deny && !dep_hit && free_v;
      end else if (dep_hit) begin
        dec_nxt.defer = 1'b1;
      end else if (is_mem && deny) begin
        dec_nxt.addr_err = 1'b1;
      end else if (is_mem && unc && iss.spec) begin
        dec_nxt.block = 1'b1;
      end else if (is_mem && iss.miss && !unc) begin
        // other slots may still be pending; only a full table waits
        dec_nxt.alloc = free_v;
        dec_nxt.grant = free_v;
        dec_nxt.defer = !free_v;
      end else begin
        dec_nxt.grant = 1'b1;
        dec_nxt.taken = iss.op == OP_BRL;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) dec_r <= '0;
    else if (ce) dec_r <= dec_nxt;
  end

  // only cached misses reach the external interface, speculative or not
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      breq_r <= '0;
    end else if (ce) begin
      breq_r.valid <= dec_nxt.alloc;
      breq_r.id    <= free_id;
      breq_r.addr  <= iss.addr[PA_W-1:0];
    end
  end

  // speculation fences
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      brl_pend_r <= 1'b0;
      ser_pend_r <= 1'b0;
    end else if (ce) begin
      if (dec_nxt.grant && iss.op == OP_BRL) brl_pend_r <= 1'b1;
      else if (brl_res) brl_pend_r <= 1'b0;
      if (dec_nxt.grant && iss.op == OP_SER) ser_pend_r <= 1'b1;
      else if (ser_done) ser_pend_r <= 1'b0;
    end
  end

  // completions: refusal frees the slot, leaves caches alone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fill_r     <= 1'b0;
      fill_id_r  <= '0;
      fault_r    <= 1'b0;
      fault_id_r <= '0;
      nacks_r    <= '0;
    end else if (ce) begin
      fill_r     <= bresp.valid && !bresp.nack;
      fill_id_r  <= bresp.id;
      fault_r    <= grad_v && nacked[grad_id];
      fault_id_r <= grad_id;
      if (bresp.valid && bresp.nack) nacks_r <= nacks_r + NACKS_W'(1);
    end
  end

  // register port
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_r <= ST_RST;
      cca_r  <= CFG_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == REG_STATUS) stat_r <= reg_wdata[2:0];
      if (reg_addr == REG_CONFIG) cca_r <= reg_wdata[CFG_CCA_LSB +: CFG_CCA_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_r <= '0;
    end else if (ce) begin
      reg_rdata_r <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_STATUS: reg_rdata_r <= {29'h0, stat_r};
          REG_CONFIG: reg_rdata_r <= {29'h0, cca_r};
          REG_MISS:   reg_rdata_r <= 32'({nacked, {(MISS_NACK_LSB - NMISS){1'b0}}, pend});
          REG_NACKS:  reg_rdata_r <= 32'(nacks_r);
          default:    reg_rdata_r <= '0;
        endcase
      end
    end
  end

  // checks
  property p_brl_taken;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && iss.op == OP_BRL && !(iss.ft && brl_pend_r) && !dep_hit |=> dec_r.taken && dec_r.grant;
  endproperty
  a_brl_taken: assert property (p_brl_taken) else $error("branch-likely not predicted taken");

  property p_ft_block;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && iss.ft && brl_pend_r |=> dec_r.block && !dec_r.grant && !breq_r.valid;
  endproperty
  a_ft_block: assert property (p_ft_block) else $error("fall-through instruction initiated");

  property p_ser_mem;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && ser_pend_r && iss.spec && !iss.ft |=> is_mem_q == dec_r.block;
  endproperty
  always_ff @(posedge clk_sys) if (ce) is_mem_q <= is_mem;
  a_ser_mem: assert property (p_ser_mem) else $error("serialize fence blocked wrong class");

  property p_cmov;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && iss.op == OP_CMOV && !(iss.ft && brl_pend_r) && !dep_hit |=> dec_r.grant;
  endproperty
  a_cmov: assert property (p_cmov) else $error("conditional move restricted");

  property p_dep;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && !iss.ft && !is_mem && iss.dep_v && pend[iss.dep_id] |=> dec_r.defer && !dec_r.grant;
  endproperty
  a_dep: assert property (p_dep) else $error("dependent instruction not deferred");

  property p_alloc_req;
    @(posedge clk_sys) disable iff (rst)
    dec_r.alloc |-> breq_r.valid && breq_r.id == dec_r.id && !dec_r.uncached;
  endproperty
  a_alloc_req: assert property (p_alloc_req) else $error("miss slot without block read");

  property p_pref;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && iss.op == OP_PREF |=> !dec_r.addr_err && !dec_r.defer;
  endproperty
  a_pref: assert property (p_pref) else $error("prefetch faulted or waited");

  property p_k0;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && is_mem && is_k0 |=> dec_r.uncached == ($past(cca_r) == CCA_UNCACHED);
  endproperty
  a_k0: assert property (p_k0) else $error("kernel segment attribute ignored");

  property p_deny;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && deny && iss.op inside {OP_LOAD, OP_STORE} && !iss.ft && !ser_pend_r && !dep_hit
      |=> dec_r.addr_err && !breq_r.valid;
  endproperty
  a_deny: assert property (p_deny) else $error("physical window not denied");

  property p_unc_spec;
    @(posedge clk_sys) disable iff (rst)
    ce && iss.valid && is_mem && unc && iss.spec |=> !breq_r.valid && (dec_r.block || dec_r.addr_err || dec_r.defer
      || iss_pref_q);
  endproperty
  always_ff @(posedge clk_sys) if (ce) iss_pref_q <= iss.op == OP_PREF;
  a_unc_spec: assert property (p_unc_spec) else $error("uncached op went out speculatively");

  property p_nack;
    @(posedge clk_sys) disable iff (rst)
    ce && grad_v && nacked[grad_id] |=> fault_r && fault_id_r == $past(grad_id);
  endproperty
  a_nack: assert property (p_nack) else $error("refused read did not fault at graduation");

  property p_nack_fill;
    @(posedge clk_sys) disable iff (rst)
    ce && bresp.valid && bresp.nack |=> !fill_r;
  endproperty
  a_nack_fill: assert property (p_nack_fill) else $error("refused read filled");

  c_brl: cover property (@(posedge clk_sys) disable iff (rst) dec_r.taken ##[1:4] dec_r.block);
  c_two_miss: cover property (@(posedge clk_sys) disable iff (rst) pend[0] && pend[1]);
  c_nack_fault: cover property (@(posedge clk_sys) disable iff (rst) fault_r);
  c_ser: cover property (@(posedge clk_sys) disable iff (rst) ser_pend_r && dec_r.block);
endmodule
`default_nettype wire

// [tb/spc_agent_model.sv]
// behavioural external agent answering block reads
`default_nettype none
module spc_agent_model import spc_pkg::*; (
  input  wire spc_breq_t  breq,    // block read from the core
  input  wire logic       clk_sys, // core clock
  input  wire logic       rst,     // sync reset
  input  wire logic [4:0] dly,     // answer delay in cycles
  input  wire logic       nack_en, // refuse every read
  output var spc_bresp_t  bresp    // completion pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int              cyc = 0;
  int              due[$];
  logic [ID_W-1:0] ids[$];
  initial bresp = '0;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // idle fields flip so a stale id is never mistaken for a live one
    bresp <= '{1'b0, ~bresp.nack, ~bresp.id};
    if (rst) begin
      due.delete();
      ids.delete();
    end else begin
      if (breq.valid === 1'b1) begin
        due.push_back(cyc + dly);
        ids.push_back(breq.id);
      end
      // one answer a cycle, in request order
      if (due.size() > 0 && cyc >= due[0]) begin
        bresp <= '{1'b1, nack_en, ids[0]};
        void'(due.pop_front());
        void'(ids.pop_front());
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the speculation control block
`default_nettype none
module tb_top import spc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] G = 7'h40, DF = 7'h20, BK = 7'h10, AE = 7'h08, TK = 7'h04, UC = 7'h02, AL = 7'h01;
  localparam logic [4:0] DEP = 5'h10, SP = 5'h08, FT = 5'h04, MS = 5'h02, TU = 5'h01;
  localparam logic [63:0] PL = 64'h0000000000040000, KS0 = 64'hffffffff80001000;
  localparam logic [63:0] XKC = 64'h9800000000001000, XKU = 64'h9000000000002000;
  logic            clk_sys, rst, brl_res, ser_done, grad_v, reg_wr, reg_rd, p_nack;
  logic [ID_W-1:0] grad_id, fill_id_r, fault_id_r;
  logic [7:0]      reg_addr;
  logic [31:0]     reg_wdata, reg_rdata_r;
  logic [4:0]      p_dly;
  logic            fill_r, fault_r;
  logic            ce;
  logic [ID_W-1:0] last_fill;
  spc_issue_t      iss;
  spc_bresp_t      bresp;
  spc_dec_t        dec_r;
  spc_breq_t       breq_r;
  int              fails = 0, checks_done = 0, fills = 0;

  spc_ctrl u_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .iss(iss), .brl_res(brl_res), .ser_done(ser_done),
    .grad_v(grad_v), .grad_id(grad_id), .bresp(bresp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .dec_r(dec_r), .breq_r(breq_r), .fill_r(fill_r),
    .fill_id_r(fill_id_r), .fault_r(fault_r), .fault_id_r(fault_id_r), .reg_rdata_r(reg_rdata_r)
  );
  spc_agent_model u_agent (
    .breq(breq_r), .clk_sys(clk_sys), .rst(rst), .dly(p_dly), .nack_en(p_nack), .bresp(bresp)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (fill_r === 1'b1) begin
      fills++;
      last_fill = fill_id_r;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // f = {dep, spec, ft, miss, tlb_uc}; id is the dependency and the slot expected
  task automatic issue(input spc_op_t op, input logic [4:0] f, input logic [63:0] a,
                       input logic [6:0] e, input logic [ID_W-1:0] id = '0);
    @(posedge clk_sys);
    iss <= '{1'b1, op, f[3], f[2], f[1], f[0], f[4], id, a};
    @(posedge clk_sys);
    iss.valid <= 1'b0;
    #1;
    // uncached is judged only on granted ops
    chk({dec_r[8:4], dec_r[2], dec_r.id & {ID_W{e[0]}}}, {e[6:2], e[0], id & {ID_W{e[0]}}});
    chk(breq_r.valid, e[0]);
    if (e[6]) chk(dec_r.uncached, e[1]);
    if (e[0]) chk(breq_r.addr, 64'(a[PA_W-1:0]));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_r, e);
  endtask
  task automatic wait_fills(input int n);
    for (int i = 0; i < 300 && fills < n; i++) @(posedge clk_sys);
    chk(fills, n);
  endtask
  task automatic grad(input logic [ID_W-1:0] id, input logic e);
    @(posedge clk_sys);
    grad_v <= 1'b1;
    grad_id <= id;
    @(posedge clk_sys);
    grad_v <= 1'b0;
    #1;
    chk({fault_r, fault_id_r & {ID_W{e}}}, {e, id & {ID_W{e}}});
  endtask

  task automatic t_regs();
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_CONFIG, 32'h3);
    rd_chk(REG_MISS, 32'h0);
    rd_chk(REG_NACKS, 32'h0);
    rd_chk(8'h10, 32'h0);
    wr(REG_MISS, 32'hffff);
    rd_chk(REG_MISS, 32'h0);
    wr(REG_CONFIG, 32'h2);
    rd_chk(REG_CONFIG, 32'h2);
    wr(REG_CONFIG, 32'h3);
    $display("test regs done");
  endtask
  task automatic t_ce();
    @(posedge clk_sys);
    ce <= 1'b0;
    iss <= '{1'b1, OP_BRL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'd0, PL};
    repeat (3) @(posedge clk_sys);
    #1;
    chk(dec_r, 64'h0);
    chk(breq_r.valid, 1'b0);
    @(posedge clk_sys);
    iss.valid <= 1'b0;
    ce <= 1'b1;
    // a frozen branch-likely must not have armed the fence
    issue(OP_OTHER, SP | FT, PL, G);
    $display("test clock enable done");
  endtask
  task automatic t_brl();
    issue(OP_BRL, SP, PL, G | TK);
    issue(OP_OTHER, SP | FT, PL, BK);
    issue(OP_STORE, SP | FT | MS, PL, BK);
    issue(OP_CMOV, SP, PL, G);
    issue(OP_LOAD, SP, PL, G);
    @(posedge clk_sys);
    brl_res <= 1'b1;
    @(posedge clk_sys);
    brl_res <= 1'b0;
    issue(OP_OTHER, SP | FT, PL, G);
    $display("test branch-likely done");
  endtask
  task automatic t_ser();
    issue(OP_SER, 5'h0, PL, G);
    issue(OP_LOAD, SP, PL, BK);
    issue(OP_STORE, SP, PL, BK);
    issue(OP_OTHER, SP, PL, G);
    issue(OP_LOAD, 5'h0, PL, G);
    @(posedge clk_sys);
    ser_done <= 1'b1;
    @(posedge clk_sys);
    ser_done <= 1'b0;
    issue(OP_LOAD, SP, PL, G);
    $display("test serializing done");
  endtask
  task automatic t_unc();
    issue(OP_LOAD, SP | MS, XKU, BK);
    issue(OP_LOAD, MS, XKU, G | UC);
    issue(OP_STORE, SP | MS | TU, PL, BK);
    issue(OP_LOAD, SP | MS, XKC, G | AL, 2'd0);
    issue(OP_LOAD, SP | MS, KS0, G | AL, 2'd1);
    wr(REG_CONFIG, 32'h2);
    issue(OP_LOAD, MS, KS0, G | UC);
    issue(OP_LOAD, SP | MS, KS0, BK);
    wr(REG_CONFIG, 32'h3);
    wait_fills(2);
    chk(last_fill, 2'd1);
    $display("test uncached done");
  endtask
  task automatic t_deny();
    wr(REG_STATUS, 32'h6);
    issue(OP_LOAD, MS, XKC, AE);
    issue(OP_STORE, 5'h0, XKU, AE);
    issue(OP_LOAD, 5'h0, KS0, G);
    issue(OP_PREF, SP | MS, XKC, G);
    wr(REG_STATUS, 32'h7);
    issue(OP_LOAD, MS, XKC, G | AL, 2'd0);
    wr(REG_STATUS, 32'h0);
    wait_fills(3);
    $display("test deny done");
  endtask
  task automatic t_miss();
    p_dly <= 5'd30;
    for (int i = 0; i < NMISS; i++) issue(OP_LOAD, SP | MS, PL + 64'(i * 64), G | AL, i[ID_W-1:0]);
    issue(OP_LOAD, SP | MS, PL + 64'h100, DF);
    issue(OP_OTHER, SP, PL, G);
    issue(OP_LOAD, SP | DEP, PL, DF, 2'd2);
    issue(OP_PREF, SP | DEP | MS, PL, G, 2'd2);
    wait_fills(7);
    issue(OP_LOAD, SP | DEP, PL, G, 2'd2);
    $display("test misses done");
  endtask
  task automatic t_nack();
    p_dly <= 5'd2;
    p_nack <= 1'b1;
    issue(OP_LOAD, SP | MS, PL, G | AL, 2'd0);
    repeat (10) @(posedge clk_sys);
    chk(fills, 7);
    rd_chk(REG_MISS, 32'h100);
    rd_chk(REG_NACKS, 32'h1);
    grad(2'd1, 1'b0);
    grad(2'd0, 1'b1);
    rd_chk(REG_MISS, 32'h0);
    p_nack <= 1'b0;
    $display("test refusal done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    iss = '0;
    {brl_res, ser_done, grad_v, reg_wr, reg_rd, p_nack} = '0;
    ce = 1'b1;
    last_fill = '0;
    grad_id = '0;
    reg_addr = '0;
    reg_wdata = '0;
    p_dly = 5'd8;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_ce();
    t_brl();
    t_ser();
    t_unc();
    t_deny();
    t_miss();
    t_nack();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
